// ===== dv/efp_host.sv
// Host processor model on the register bus
`timescale 1ns/1ps
module efp_host
  import efp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic [11:0] o_paddr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  logic [31:0] last_rd = 32'h0;
  logic last_err = 1'h0;
  initial
  begin
    {o_paddr, o_psel, o_penable, o_pwrite, o_pwdata, o_pstrb} = '0;
  end
  // Request held until pready is seen or 1000 cycles pass; no fixed latency assumed
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge i_clk);
    o_psel <= 1'h1;
    o_paddr <= addr;
    o_pwrite <= wr;
    o_pwdata <= wd;
    o_pstrb <= 4'hf;
    @(posedge i_clk);
    o_penable <= 1'h1;
    @(posedge i_clk);
    while (i_pready !== 1'h1 && n < 1000)
    begin
      @(posedge i_clk);
      n++;
    end
    last_rd = i_prdata;
    last_err = i_pslverr;
    o_psel <= 1'h0;
    o_penable <= 1'h0;
  endtask
  // No data reads until the skip bit reads low again
  task automatic skip_frame();
    int n;
    n = 0;
    xfer(1'h1, EFP_RX_DATAPATH_ADDR, 32'h80000000);
    do
    begin
      xfer(1'h0, EFP_RX_DATAPATH_ADDR, 32'h0);
      n++;
    end while (last_rd[31] !== 1'h0 && n < 50);
  endtask
endmodule // efp_host

// ===== dv/testbench.sv
// Self-checking bench for the FIFO partition block
`timescale 1ns/1ps
module testbench
  import efp_pkg::*;
;
  logic clk, rst_b, rx_wv, rx_fe, rx_dr, rx_sr, tx_wv, tx_take;
  logic [15:0] rx_len;
  logic [11:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, tx_load, rx_full, rx_drop;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  int tx_loads = 0;
  int tx, rx;
  efp_top u_efp_top (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_PADDR(paddr), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_WORD_VALID(rx_wv),
    .I_RX_FRAME_END(rx_fe), .I_RX_FRAME_LEN(rx_len), .I_RX_DATA_READ(rx_dr),
    .I_RX_STS_READ(rx_sr), .I_TX_WORD_VALID(tx_wv), .I_MAC_TX_TAKE(tx_take),
    .O_TX_STAGE_LOAD(tx_load), .O_RX_DATA_FULL(rx_full), .O_RX_DROPPING(rx_drop));
  efp_host u_efp_host (.i_clk(clk), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_paddr(paddr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_pwdata(pwdata), .o_pstrb(pstrb));
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    u_efp_host.xfer(1'h0, a, 32'h0);
    chk(u_efp_host.last_rd & m, exp);
  endtask
  // Words arrive back to back, then the frame end strobe
  task automatic rx_frame(input int words, input logic [15:0] len);
    repeat (words) @(posedge clk) rx_wv <= 1'h1;
    @(posedge clk);
    rx_wv <= 1'h0;
    rx_fe <= 1'h1;
    rx_len <= len;
    @(posedge clk) rx_fe <= 1'h0;
    repeat (words + 8) @(posedge clk);
  endtask
  task automatic pop(input logic sts);
    @(posedge clk);
    if (sts) rx_sr <= 1'h1;
    else rx_dr <= 1'h1;
    @(posedge clk);
    rx_sr <= 1'h0;
    rx_dr <= 1'h0;
  endtask
  // Hang guard: well above the several hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (tx_load === 1'h1) tx_loads++;
    if (cycles == 10000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    {rst_b, rx_wv, rx_fe, rx_dr, rx_sr, tx_wv, tx_take, rx_len} = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    rdm(EFP_RX_FIFO_OCC_ADDR, 32'h0, 32'hffffffff);
    rdm(EFP_RX_DATAPATH_ADDR, 32'h0, 32'h80000000);
    rdm(12'h0f0, 32'h0, 32'hffffffff);
    chk({31'h0, u_efp_host.last_err}, 32'h1);
    for (int n = 2; n <= 14; n++)
    begin
      tx = n * 1024 - 512;
      rx = (16384 - n * 1024) - (16384 - n * 1024) / 16;
      u_efp_host.xfer(1'h1, EFP_HW_CONFIG_ADDR, 32'(n << 16));
      rdm(EFP_ALLOC_INFO_ADDR, {rx[15:0], tx[15:0]}, 32'hffffffff);
    end
    rx_frame(3, 16'd10);
    rdm(EFP_RX_FIFO_OCC_ADDR, 32'h0001000c, 32'hffffffff);
    u_efp_host.skip_frame();
    chk(u_efp_host.last_rd, 32'h0);
    rdm(EFP_RX_FIFO_OCC_ADDR, 32'h0, 32'hffff);
    rx_frame(2, 16'd8);
    rdm(EFP_RX_FIFO_OCC_ADDR, 32'h8, 32'hffff);
    pop(1'h0);
    rdm(EFP_RX_FIFO_OCC_ADDR, 32'h4, 32'hffff);
    pop(1'h1);
    pop(1'h1);
    rdm(EFP_RX_FIFO_OCC_ADDR, 32'h0, 32'hff0000);
    pop(1'h0);
    repeat (4)
    begin
      @(posedge clk) tx_wv <= 1'h1;
      @(posedge clk) tx_wv <= 1'h0;
      @(posedge clk) tx_take <= 1'h1;
      @(posedge clk) tx_take <= 1'h0;
    end
    repeat (8) @(posedge clk);
    chk(32'(tx_loads), 32'h4);
    rdm(EFP_RX_FIFO_OCC_ADDR, 32'h0, 32'hffffffff);
    repeat (540) @(posedge clk) rx_wv <= 1'h1;
    @(posedge clk) rx_wv <= 1'h0;
    repeat (4) @(posedge clk);
    chk({31'h0, rx_full}, 32'h1);
    chk({31'h0, rx_drop}, 32'h1);
    rdm(EFP_RX_FIFO_OCC_ADDR, 32'd1904, 32'hffff);
    @(posedge clk);
    rx_fe <= 1'h1;
    rx_len <= 16'd2160;
    @(posedge clk) rx_fe <= 1'h0;
    rdm(EFP_RX_DROP_ADDR, 32'h1, 32'hffffffff);
    print_verdict();
  end
endmodule // testbench

// ===== verilog/efp_pkg.sv
// Package: constants for the Ethernet FIFO partition block
package efp_pkg;
  // ----------------------------------------
  // Buffer geometry
  // ----------------------------------------
  localparam int unsigned EFP_TOTAL_BYTES = 16384;
  localparam int unsigned EFP_TX_STS_BYTES = 512;
  localparam int unsigned EFP_TX_STS_WORDS = 128;
  localparam int unsigned EFP_KB_BYTES = 1024;
  localparam int unsigned EFP_RX_STS_DIV = 16;
  localparam int unsigned EFP_RX_FULL_MARGIN_DW = 4;
  localparam int unsigned EFP_TX_STAGE_BYTES = 2048;
  localparam int unsigned EFP_RX_STAGE_BYTES = 128;
  localparam int unsigned EFP_DW_BYTES = 4;
  localparam logic [3:0] EFP_ALLOC_MIN = 4'h2;
  localparam logic [3:0] EFP_ALLOC_MAX = 4'he;
  localparam logic [3:0] EFP_ALLOC_RESET = 4'h5;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] EFP_HW_CONFIG_ADDR = 12'h074;
  localparam logic [11:0] EFP_RX_DATAPATH_ADDR = 12'h078;
  localparam logic [11:0] EFP_RX_FIFO_OCC_ADDR = 12'h07c;
  localparam logic [11:0] EFP_RX_DROP_ADDR = 12'h0a0;
  localparam logic [11:0] EFP_ALLOC_INFO_ADDR = 12'h0a4;
  localparam int unsigned EFP_SKIP_BIT = 31;
  localparam int unsigned EFP_ALLOC_LSB = 16;
  localparam int unsigned EFP_STS_LSB = 16;
endpackage

// ===== verilog/efp_stage.sv
// Staging buffer occupancy tracker on the MAC side
`timescale 1ns/1ps
module efp_stage
  import efp_pkg::*;
#(
  parameter int unsigned DEPTH_BYTES = 128
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_push,
  input wire logic [15:0] i_push_bytes,
  input wire logic i_pop,
  input wire logic [15:0] i_pop_bytes,
  output logic [15:0] o_level,
  output logic o_room
);
  initial
  begin
    if (DEPTH_BYTES == 0 || DEPTH_BYTES > 65535)
      $error("efp_stage: bad depth");
  end

  typedef struct packed {
    logic [15:0] level;
  } efp_stage_t;

  efp_stage_t st;
  efp_stage_t next_st;

  always_comb
  begin
    next_st = st;
    if (i_push)
      next_st.level = next_st.level + i_push_bytes;
    if (i_pop)
      next_st.level = next_st.level - i_pop_bytes;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_level = st.level;
  assign o_room = (32'(st.level) < DEPTH_BYTES);
endmodule // efp_stage

// ===== verilog/efp_top.sv
// Ethernet FIFO partition: allocation split, staging, skip and occupancy
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - Fixed 512-byte transmit status FIFO
// - Transmit data size is allocation minus status
// - Commands and payload share transmit data space
// - Receive gets buffer minus transmit allocation
// - Receive status is one sixteenth
// - Setting N gives N kilobytes transmit
// - Receive data full four DWORDs early
// - Fixed 2K and 128 byte staging buffers
// - Refill transmit staging from transmit data FIFO
// - Receive data passes through staging buffer
// - Overrun drops frames, counts each one
// - Staging levels hidden from host
// - Skip bit advances to next frame
// - Status word usage in bits 23-16
// - Data byte usage in bits 15-0
module efp_top
  import efp_pkg::*;
#(
  parameter int unsigned FRAME_DEPTH = 64
)
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic [11:0] I_PADDR,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_RX_WORD_VALID,
  input wire logic I_RX_FRAME_END,
  input wire logic [15:0] I_RX_FRAME_LEN,
  input wire logic I_RX_DATA_READ,
  input wire logic I_RX_STS_READ,
  input wire logic I_TX_WORD_VALID,
  input wire logic I_MAC_TX_TAKE,
  output logic O_TX_STAGE_LOAD,
  output logic O_RX_DATA_FULL,
  output logic O_RX_DROPPING
);
  initial
  begin
    if (FRAME_DEPTH < 2 || FRAME_DEPTH > 256)
      $error("efp_top: bad frame depth");
  end

  // ----------------------------------------
  // Partition arithmetic
  // ----------------------------------------
  function automatic logic [15:0] tx_total(input logic [3:0] n);
    tx_total = 16'(32'(n) * EFP_KB_BYTES);
  endfunction

  function automatic logic [15:0] rx_total(input logic [3:0] n);
    rx_total = 16'(EFP_TOTAL_BYTES - 32'(tx_total(n)));
  endfunction

  function automatic logic [15:0] rx_data_size(input logic [3:0] n);
    rx_data_size = rx_total(n) - 16'(32'(rx_total(n)) / EFP_RX_STS_DIV);
  endfunction

  localparam int unsigned FW = $clog2(FRAME_DEPTH);

  typedef struct packed {
    logic [3:0] alloc;
    logic skip;
    logic [15:0] data_used;
    logic [7:0] sts_used;
    logic [31:0] drop_cnt;
    logic dropping;
    logic [15:0] cur_len;
    logic [15:0] head_left;
    logic [FW:0] frames;
    logic [15:0] tx_data_used;
    logic tx_load;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic data_full;
  } efp_top_t;

  efp_top_t st;
  efp_top_t next_st;

  // Frame lengths in DWORD-rounded bytes, oldest first
  logic [15:0] len_q [FRAME_DEPTH];
  logic [FW-1:0] wr_ptr;
  logic [FW-1:0] rd_ptr;

  logic [15:0] rx_stage_level;
  logic rx_stage_room;
  logic [15:0] tx_stage_level;
  logic tx_stage_room;
  logic rx_full;
  logic rx_move;
  logic rx_frame_done;
  logic [15:0] rnd_len;
  logic acc;
  logic wr;
  logic rd_word;
  logic skip_done;

  assign rx_full = (32'(st.data_used) + EFP_RX_FULL_MARGIN_DW * EFP_DW_BYTES)
    >= 32'(rx_data_size(st.alloc));
  assign rx_move = (rx_stage_level >= 16'(EFP_DW_BYTES)) && !rx_full;
  assign rnd_len = (I_RX_FRAME_LEN + 16'h0003) & 16'hfffc;
  assign rx_frame_done = I_RX_FRAME_END && !st.dropping
    && (32'(st.frames) < FRAME_DEPTH);
  assign acc = I_PSEL && I_PENABLE && !st.pready;
  assign wr = acc && I_PWRITE;
  assign rd_word = I_RX_DATA_READ && !st.skip && (st.data_used >= 16'(EFP_DW_BYTES));
  assign skip_done = st.skip;

  // ----------------------------------------
  // Staging buffers
  // ----------------------------------------
  efp_stage #(.DEPTH_BYTES(EFP_RX_STAGE_BYTES)) u_rx_stage (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_push(I_RX_WORD_VALID && !st.dropping && rx_stage_room),
    .i_push_bytes(16'(EFP_DW_BYTES)),
    .i_pop(rx_move),
    .i_pop_bytes(16'(EFP_DW_BYTES)),
    .o_level(rx_stage_level),
    .o_room(rx_stage_room)
  );

  efp_stage #(.DEPTH_BYTES(EFP_TX_STAGE_BYTES)) u_tx_stage (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_push(next_st.tx_load),
    .i_push_bytes(16'(EFP_DW_BYTES)),
    .i_pop(I_MAC_TX_TAKE && tx_stage_level != 16'h0000),
    .i_pop_bytes(16'(EFP_DW_BYTES)),
    .o_level(tx_stage_level),
    .o_room(tx_stage_room)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.pready = acc;
    next_st.pslverr = 1'b0;
    // Transmit data FIFO holds commands and payload alike
    if (I_TX_WORD_VALID && 32'(st.tx_data_used) + EFP_DW_BYTES
        <= 32'(tx_total(st.alloc)) - EFP_TX_STS_BYTES)
      next_st.tx_data_used = next_st.tx_data_used + 16'(EFP_DW_BYTES);
    next_st.tx_load = tx_stage_room && (st.tx_data_used >= 16'(EFP_DW_BYTES));
    if (next_st.tx_load)
      next_st.tx_data_used = next_st.tx_data_used - 16'(EFP_DW_BYTES);
    // Receive frame accounting
    if (I_RX_WORD_VALID && !rx_stage_room && !st.dropping)
      next_st.dropping = 1'b1;
    if (I_RX_FRAME_END && st.dropping)
      next_st.drop_cnt = st.drop_cnt + 32'h0000_0001;
    if (st.dropping && !rx_full && I_RX_FRAME_END)
      next_st.dropping = 1'b0;
    if (rx_frame_done)
    begin
      next_st.frames = st.frames + 1'b1;
      if (st.sts_used != 8'hff)
        next_st.sts_used = st.sts_used + 8'h01;
    end
    if (rx_move)
      next_st.data_used = next_st.data_used + 16'(EFP_DW_BYTES);
    if (I_RX_STS_READ && st.sts_used != 8'h00 && !rx_frame_done)
      next_st.sts_used = st.sts_used - 8'h01;
    // Head frame consumption by reads or skip
    if (st.frames != '0 && st.head_left == 16'h0000)
      next_st.head_left = len_q[rd_ptr];
    if (rd_word)
    begin
      next_st.data_used = next_st.data_used - 16'(EFP_DW_BYTES);
      if (st.head_left > 16'(EFP_DW_BYTES))
        next_st.head_left = st.head_left - 16'(EFP_DW_BYTES);
      else
      begin
        next_st.head_left = 16'h0000;
        next_st.frames = next_st.frames - 1'b1;
      end
    end
    if (skip_done)
    begin
      next_st.skip = 1'b0;
      if (st.frames != '0)
      begin
        next_st.data_used = next_st.data_used
          - ((st.head_left != 16'h0000) ? st.head_left : len_q[rd_ptr]);
        next_st.head_left = 16'h0000;
        next_st.frames = next_st.frames - 1'b1;
      end
    end
    // Register writes
    if (wr && I_PADDR == EFP_RX_DATAPATH_ADDR && I_PSTRB[3] && I_PWDATA[EFP_SKIP_BIT])
      next_st.skip = 1'b1;
    if (wr && I_PADDR == EFP_HW_CONFIG_ADDR && I_PSTRB[2])
      next_st.alloc = I_PWDATA[EFP_ALLOC_LSB +: 4];
    // Register reads; staging levels are never exposed
    if (acc && !I_PWRITE)
    begin
      unique case (I_PADDR)
        EFP_HW_CONFIG_ADDR: next_st.prdata = {12'h000, st.alloc, 16'h0000};
        EFP_RX_DATAPATH_ADDR: next_st.prdata = {st.skip, 31'h0000_0000};
        EFP_RX_FIFO_OCC_ADDR: next_st.prdata = {8'h00, st.sts_used, st.data_used};
        EFP_RX_DROP_ADDR: next_st.prdata = st.drop_cnt;
        EFP_ALLOC_INFO_ADDR: next_st.prdata = {rx_data_size(st.alloc),
          16'(32'(tx_total(st.alloc)) - EFP_TX_STS_BYTES)};
        default:
        begin
          next_st.prdata = 32'h0000_0000;
          next_st.pslverr = 1'b1;
        end
      endcase
    end
    else if (acc)
      next_st.pslverr = !(I_PADDR == EFP_HW_CONFIG_ADDR || I_PADDR == EFP_RX_DATAPATH_ADDR
        || I_PADDR == EFP_RX_FIFO_OCC_ADDR || I_PADDR == EFP_RX_DROP_ADDR
        || I_PADDR == EFP_ALLOC_INFO_ADDR);
    // Full flag registered so the pin never shows an adder glitch
    next_st.data_full = (32'(next_st.data_used) + EFP_RX_FULL_MARGIN_DW * EFP_DW_BYTES)
      >= 32'(rx_data_size(next_st.alloc));
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      st <= '0;
      st.alloc <= EFP_ALLOC_RESET;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      st <= next_st;
      if (rx_frame_done)
        wr_ptr <= FW'((32'(wr_ptr) + 1) % FRAME_DEPTH);
      if (st.frames != '0 && next_st.frames < st.frames + (rx_frame_done ? 1 : 0))
        rd_ptr <= FW'((32'(rd_ptr) + 1) % FRAME_DEPTH);
    end
  end

  // Length queue has no reset; only entries below the frame count are read
  always_ff @(posedge I_CORE_CLK)
  begin
    if (rx_frame_done)
      len_q[wr_ptr] <= rnd_len;
  end

  assign O_PRDATA = st.prdata;
  assign O_PREADY = st.pready;
  assign O_PSLVERR = st.pslverr;
  assign O_TX_STAGE_LOAD = st.tx_load;
  assign O_RX_DATA_FULL = st.data_full;
  assign O_RX_DROPPING = st.dropping;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  skip_clears_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    st.skip |=> !st.skip)
    else $error("skip bit did not self-clear");

  drop_count_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (st.dropping && I_RX_FRAME_END) |=> st.drop_cnt == $past(st.drop_cnt) + 32'h1)
    else $error("dropped frame not counted");

  tx_limit_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    32'(st.tx_data_used) <= 32'(tx_total(st.alloc)) - EFP_TX_STS_BYTES)
    else $error("transmit data over allocation");

  no_move_full_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    rx_full |-> !rx_move)
    else $error("moved into full receive FIFO");

  skip_set_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (wr && I_PADDR == EFP_RX_DATAPATH_ADDR && I_PSTRB[3] && I_PWDATA[31]) |=> st.skip)
    else $error("skip write did not set the bit");

  data_move_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (rx_move && !rd_word && !skip_done) |=> st.data_used == $past(st.data_used) + 16'h0004)
    else $error("moved word not counted");

  drop_block_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (st.dropping && !rx_move) |=> rx_stage_level == $past(rx_stage_level))
    else $error("word kept while dropping");

  sts_read_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_RX_STS_READ && st.sts_used != 8'h00 && !rx_frame_done)
    |=> st.sts_used == $past(st.sts_used) - 8'h01)
    else $error("status read not counted");

  // Margin keeps room for the staging drain in flight
  full_pin_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    O_RX_DATA_FULL == rx_full)
    else $error("full pin disagrees with full state");
endmodule // efp_top
